/* logic/cbcld_defines.svh */
/*
 * offsets, field positions, reset values and address constants of the
 * bit, control and literal decoder.
 * assumes 32-bit classic wishbone with word-aligned byte addresses.
 */
`ifndef CBCLD_DEFINES_SVH
`define CBCLD_DEFINES_SVH

// ==========================================================
// register offsets
`define CBCLD_OFS_CTRL 8'h00
`define CBCLD_OFS_STATUS 8'h04
`define CBCLD_OFS_TBLPTR 8'h08
`define CBCLD_OFS_PTR0 8'h0c
`define CBCLD_OFS_PTR1 8'h10
`define CBCLD_OFS_PTR2 8'h14

// ==========================================================
// field positions
`define CBCLD_CTRL_PRESC_ASSIGNED 0
`define CBCLD_CTRL_TABLE_WRITE_OP_ENABLE 1
`define CBCLD_ST_TIMEOUT 0
`define CBCLD_ST_POWERDOWN 1
`define CBCLD_ST_STANDBY 2
`define CBCLD_ST_WR_BUSY 3
`define CBCLD_ST_GIE 4
`define CBCLD_ST_PEIE 5
`define CBCLD_ST_BSR_LSB 8
`define CBCLD_FLAG_C 0
`define CBCLD_FLAG_DC 1
`define CBCLD_FLAG_Z 2
`define CBCLD_FLAG_OV 3
`define CBCLD_FLAG_N 4

// ==========================================================
// reset values and addresses
`define CBCLD_RST_CTRL 2'h0
`define CBCLD_RST_TIMEOUT 1'b1
`define CBCLD_RST_POWERDOWN 1'b1
`define CBCLD_TIMER0_ADDR 8'hd6
`define CBCLD_PORT_FIRST 8'h80
`define CBCLD_PORT_LAST 8'h84
`define CBCLD_MASK_ARITH 5'h1f
`define CBCLD_MASK_LOGIC 5'h14

`endif

/* logic/cbcld_pkg.sv */
/*
 * types of the bit, control and literal decoder.
 * assumes nothing beyond the decoder itself.
 */
package cbcld_pkg;

    // ==========================================================
    // decoded operations
    typedef enum logic [4:0] {
        nop_op, bit_clear_op, bit_set_op, bit_toggle_op,
        bit_test_skip_clear_op, bit_test_skip_set_op, cond_branch_op,
        unconditional_branch_op, call_op, absolute_jump_op,
        watchdog_clear_op, standby_op, soft_reset_op,
        interrupt_return_op, subroutine_return_op, return_with_literal_op,
        push_op, pop_op, add_literal_op, subtract_from_literal_op,
        and_literal_op, or_literal_op, xor_literal_op,
        bank_select_load_op, pointer_load_op, table_read_op,
        table_write_op, other_op
    } cbcld_op_t;

    // ==========================================================
    // sequencer states
    typedef enum logic [2:0] {
        st_first, st_call2, st_jump2, st_ptr2, st_flush
    } cbcld_state_t;

    // ==========================================================
    // status flags in from the alu
    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } cbcld_flags_t;

    // ==========================================================
    // decoded word out to the datapath
    typedef struct packed {
        cbcld_op_t op;
        logic [7:0] file_addr;
        logic [2:0] bit_pos;
        logic access;
        logic [7:0] literal;
        logic [10:0] offset;
        logic [20:0] addr;
        logic [1:0] sel;
        logic [4:0] flag_mask;
        logic pc_write;
        logic wr_en;
        logic [7:0] wr_byte;
        logic pins_src;
    } cbcld_dec_t;

endpackage : cbcld_pkg

/* logic/cbcld_decoder.sv */
/*
 * bit, control, literal and table instruction decoder with wishbone
 * registers. assumes instruction words, file read data and alu flags
 * arrive on ref_clk_i; port pins arrive asynchronously.
 */
// Chosen here: the register addresses and the Wishbone register port.
// Function
// - opcodes 1011/1010 test a bit and skip if clear or set
// - 1110 0ccc branches on eight flag conditions, extra cycle taken
// - 1101 0 branches relative by 11 bits, always two cycles
// - call is two words, shadow bit and 20-bit target
// - absolute jump is two words with 20-bit target
// - watchdog clear restarts watchdog and updates timeout/powerdown
// - standby entry enters standby, updates timeout/powerdown
// - 00ff resets the device; timeout, powerdown, both enables and bank select reloaded, standby and write-busy kept
// - interrupt return reenables both enables, s restores shadow
// - return with literal loads working register, returns, two cycles
// - push and pop move stack top entry, no flags
// - add and subtract literal update c, dc, z, ov, n
// - and, or, xor literal update only z and n
// - bank select load writes low four bits
// - pointer load is two words placing 12-bit literal
// - table read with four pointer adjust modes, two cycles; the decoder adds no no-op cycle after it
// - table write with same four modes, two cycles; the decoder adds no no-op cycle after it
// - a started memory write runs until it completes
// - pc change by a one-word instruction or true test makes next cycle a no-op; call and absolute jump do not
// - lone second word of two-word instruction is a no-op
// - port read-modify-write takes pin levels as source
// - modifying timer-zero register clears assigned prescaler
`timescale 1ns/100ps
`include "cbcld_defines.svh"

module cbcld_decoder #(
    parameter int TP_W = 21
) (
    // clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    // instruction stream
    input wire logic [15:0] instr_i,
    input wire logic instr_valid_i,
    input wire logic [7:0] file_rd_i,
    input wire cbcld_pkg::cbcld_flags_t flags_i,
    input wire logic [7:0] port_pins_i,
    input wire logic wake_i,
    input wire logic mem_wr_done_i,
    // decoded output and side effects
    output logic [$bits(cbcld_pkg::cbcld_dec_t)-1:0] dec_o,
    output logic dec_valid_o,
    output logic wdt_restart_o,
    output logic soft_reset_o,
    output logic presc_clr_o,
    output logic mem_wr_start_o,
    output logic standby_o,
    // wishbone slave
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);

    cbcld_pkg::cbcld_state_t st_q, st_d;
    cbcld_pkg::cbcld_dec_t dec_q, d;
    logic [7:0] lo_q, lo_d;
    logic shadow_q, shadow_d;
    logic [1:0] ctrl_q;
    logic timeout_q, powerdown_q, standby_q, wr_busy_q;
    logic gie_q, peie_q;
    logic [3:0] bsr_q;
    logic [TP_W-1:0] tp_q;
    logic [11:0] ptr_q [3];
    logic [7:0] s1_q, s2_q, s3_q, pins_q;
    logic [7:0] src;
    logic cond, fire, take;
    logic valid_q, wdt_q, rst_q, presc_q, mst_q, ack_q;
    logic [31:0] rdat_q;
    logic bus_req;

    // ==========================================================
    // pin synchroniser
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin
            always_ff @(posedge ref_clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                    s3_q[gi] <= 1'b0;
                    pins_q[gi] <= 1'b0;
                end else if (ce_i) begin
                    s1_q[gi] <= port_pins_i[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    if (s2_q[gi] == s3_q[gi]) begin
                        pins_q[gi] <= s3_q[gi];
                    end
                end
            end
        end
    endgenerate

    assign fire = ce_i && instr_valid_i;

    // ==========================================================
    // decode
    always_comb begin
        d = '0;
        d.op = cbcld_pkg::nop_op;
        st_d = st_q;
        lo_d = lo_q;
        shadow_d = shadow_q;
        take = 1'b0;
        d.file_addr = instr_i[7:0];
        d.bit_pos = instr_i[11:9];
        d.access = instr_i[8];
        d.literal = instr_i[7:0];
        d.offset = instr_i[10:0];
        d.sel = instr_i[1:0];
        d.pins_src = !instr_i[8] && instr_i[7:0] >= `CBCLD_PORT_FIRST
            && instr_i[7:0] <= `CBCLD_PORT_LAST;
        src = d.pins_src ? pins_q : file_rd_i;
        case (instr_i[10:9])
            2'h0: cond = flags_i.z;
            2'h1: cond = flags_i.c;
            2'h2: cond = flags_i.ov;
            default: cond = flags_i.n;
        endcase
        cond = cond ^ instr_i[8];
        case (st_q)
            cbcld_pkg::st_flush: begin
                st_d = cbcld_pkg::st_first;
            end
            cbcld_pkg::st_call2: begin
                st_d = cbcld_pkg::st_first;
                if (instr_i[15:12] == 4'hf) begin
                    d.op = cbcld_pkg::call_op;
                    d.addr = {1'b0, instr_i[11:0], lo_q};
                    d.sel = {1'b0, shadow_q};
                    d.pc_write = 1'b1;
                end
            end
            cbcld_pkg::st_jump2: begin
                st_d = cbcld_pkg::st_first;
                if (instr_i[15:12] == 4'hf) begin
                    d.op = cbcld_pkg::absolute_jump_op;
                    d.addr = {1'b0, instr_i[11:0], lo_q};
                    d.pc_write = 1'b1;
                end
            end
            cbcld_pkg::st_ptr2: begin
                st_d = cbcld_pkg::st_first;
                if (instr_i[15:8] == 8'hf0) begin
                    d.op = cbcld_pkg::pointer_load_op;
                    d.addr = {9'h000, lo_q[3:0], instr_i[7:0]};
                    d.sel = lo_q[5:4];
                end
            end
            cbcld_pkg::st_first: begin
                casez (instr_i)
                    16'h0003: d.op = cbcld_pkg::standby_op;
                    16'h0004: d.op = cbcld_pkg::watchdog_clear_op;
                    16'h0005: d.op = cbcld_pkg::push_op;
                    16'h0006: d.op = cbcld_pkg::pop_op;
                    16'h00ff: d.op = cbcld_pkg::soft_reset_op;
                    16'b0000_0000_0001_000?: begin
                        d.op = cbcld_pkg::interrupt_return_op;
                        d.pc_write = 1'b1;
                    end
                    16'b0000_0000_0001_001?: begin
                        d.op = cbcld_pkg::subroutine_return_op;
                        d.pc_write = 1'b1;
                    end
                    16'b0000_0000_0000_10??: begin
                        d.op = cbcld_pkg::table_read_op;
                    end
                    16'b0000_0000_0000_11??: begin
                        d.op = cbcld_pkg::table_write_op;
                    end
                    16'b0000_0001_0000_????: begin
                        d.op = cbcld_pkg::bank_select_load_op;
                    end
                    16'b0000_1111_????_????: begin
                        d.op = cbcld_pkg::add_literal_op;
                        d.flag_mask = `CBCLD_MASK_ARITH;
                    end
                    16'b0000_1000_????_????: begin
                        d.op = cbcld_pkg::subtract_from_literal_op;
                        d.flag_mask = `CBCLD_MASK_ARITH;
                    end
                    16'b0000_1011_????_????: begin
                        d.op = cbcld_pkg::and_literal_op;
                        d.flag_mask = `CBCLD_MASK_LOGIC;
                    end
                    16'b0000_1001_????_????: begin
                        d.op = cbcld_pkg::or_literal_op;
                        d.flag_mask = `CBCLD_MASK_LOGIC;
                    end
                    16'b0000_1010_????_????: begin
                        d.op = cbcld_pkg::xor_literal_op;
                        d.flag_mask = `CBCLD_MASK_LOGIC;
                    end
                    16'b0000_1100_????_????: begin
                        d.op = cbcld_pkg::return_with_literal_op;
                        d.pc_write = 1'b1;
                    end
                    16'b1001_????_????_????: begin
                        d.op = cbcld_pkg::bit_clear_op;
                        d.wr_en = 1'b1;
                        d.wr_byte = src & ~(8'h01 << instr_i[11:9]);
                    end
                    16'b1000_????_????_????: begin
                        d.op = cbcld_pkg::bit_set_op;
                        d.wr_en = 1'b1;
                        d.wr_byte = src | (8'h01 << instr_i[11:9]);
                    end
                    16'b0111_????_????_????: begin
                        d.op = cbcld_pkg::bit_toggle_op;
                        d.wr_en = 1'b1;
                        d.wr_byte = src ^ (8'h01 << instr_i[11:9]);
                    end
                    16'b1011_????_????_????: begin
                        d.op = cbcld_pkg::bit_test_skip_clear_op;
                        take = !file_rd_i[instr_i[11:9]];
                    end
                    16'b1010_????_????_????: begin
                        d.op = cbcld_pkg::bit_test_skip_set_op;
                        take = file_rd_i[instr_i[11:9]];
                    end
                    16'b1110_0???_????_????: begin
                        d.op = cbcld_pkg::cond_branch_op;
                        d.offset = {{3{instr_i[7]}}, instr_i[7:0]};
                        d.pc_write = cond;
                    end
                    16'b1101_0???_????_????: begin
                        d.op = cbcld_pkg::unconditional_branch_op;
                        d.pc_write = 1'b1;
                    end
                    16'b1110_110?_????_????: begin
                        st_d = cbcld_pkg::st_call2;
                        lo_d = instr_i[7:0];
                        shadow_d = instr_i[8];
                    end
                    16'b1110_1111_????_????: begin
                        st_d = cbcld_pkg::st_jump2;
                        lo_d = instr_i[7:0];
                    end
                    16'b1110_1110_00??_????: begin
                        st_d = cbcld_pkg::st_ptr2;
                        lo_d = instr_i[7:0];
                    end
                    16'b1111_????_????_????: d.op = cbcld_pkg::nop_op;
                    16'h0000: d.op = cbcld_pkg::nop_op;
                    default: d.op = cbcld_pkg::other_op;
                endcase
                d.addr = (TP_W)'(instr_i[1:0] == 2'h3 ? tp_q + 1'b1 : tp_q);
                if (take || d.pc_write) begin
                    st_d = cbcld_pkg::st_flush;
                end
            end
            default: st_d = cbcld_pkg::st_first;
        endcase
    end

    // ==========================================================
    // sequencer and decode register
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q <= cbcld_pkg::st_first;
            lo_q <= 8'h00;
            shadow_q <= 1'b0;
            dec_q <= '0;
            valid_q <= 1'b0;
        end else if (ce_i) begin
            valid_q <= instr_valid_i;
            if (instr_valid_i) begin
                st_q <= st_d;
                lo_q <= lo_d;
                shadow_q <= shadow_d;
                dec_q <= d;
            end
        end
    end

    // ==========================================================
    // side effect pulses
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wdt_q <= 1'b0;
            rst_q <= 1'b0;
            presc_q <= 1'b0;
        end else if (ce_i) begin
            wdt_q <= fire && (d.op == cbcld_pkg::watchdog_clear_op
                || d.op == cbcld_pkg::standby_op);
            rst_q <= fire && d.op == cbcld_pkg::soft_reset_op;
            presc_q <= fire && d.wr_en && !d.access
                && d.file_addr == `CBCLD_TIMER0_ADDR
                && ctrl_q[`CBCLD_CTRL_PRESC_ASSIGNED];
        end
    end

    // ==========================================================
    // power and interrupt state
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            timeout_q <= `CBCLD_RST_TIMEOUT;
            powerdown_q <= `CBCLD_RST_POWERDOWN;
            standby_q <= 1'b0;
            gie_q <= 1'b0;
            peie_q <= 1'b0;
            bsr_q <= 4'h0;
        end else if (ce_i) begin
            if (standby_q && wake_i) begin
                standby_q <= 1'b0;
            end
            if (fire) begin
                case (d.op)
                    cbcld_pkg::watchdog_clear_op: begin
                        timeout_q <= 1'b1;
                        powerdown_q <= 1'b1;
                    end
                    cbcld_pkg::standby_op: begin
                        timeout_q <= 1'b1;
                        powerdown_q <= 1'b0;
                        standby_q <= 1'b1;
                    end
                    cbcld_pkg::soft_reset_op: begin
                        timeout_q <= `CBCLD_RST_TIMEOUT;
                        powerdown_q <= `CBCLD_RST_POWERDOWN;
                        gie_q <= 1'b0;
                        peie_q <= 1'b0;
                        bsr_q <= 4'h0;
                    end
                    cbcld_pkg::interrupt_return_op: begin
                        gie_q <= 1'b1;
                        peie_q <= 1'b1;
                    end
                    cbcld_pkg::bank_select_load_op: bsr_q <= d.literal[3:0];
                    default: bsr_q <= bsr_q;
                endcase
            end
        end
    end

    // ==========================================================
    // pointers and table memory write
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tp_q <= '0;
            ptr_q <= '{default: 12'h000};
            wr_busy_q <= 1'b0;
            mst_q <= 1'b0;
        end else if (ce_i) begin
            mst_q <= 1'b0;
            if (wr_busy_q && mem_wr_done_i) begin
                wr_busy_q <= 1'b0;
            end
            if (bus_req && wb_we_i && wb_adr_i == `CBCLD_OFS_TBLPTR) begin
                tp_q <= wb_dat_i[TP_W-1:0];
            end else if (fire && (d.op == cbcld_pkg::table_read_op
                    || d.op == cbcld_pkg::table_write_op)) begin
                case (d.sel)
                    2'h1: tp_q <= tp_q + 1'b1;
                    2'h2: tp_q <= tp_q - 1'b1;
                    2'h3: tp_q <= tp_q + 1'b1;
                    default: tp_q <= tp_q;
                endcase
            end
            if (fire && d.op == cbcld_pkg::table_write_op
                    && ctrl_q[`CBCLD_CTRL_TABLE_WRITE_OP_ENABLE] && !wr_busy_q) begin
                wr_busy_q <= 1'b1;
                mst_q <= 1'b1;
            end
            if (fire && d.op == cbcld_pkg::pointer_load_op
                    && d.sel != 2'h3) begin
                ptr_q[d.sel] <= d.addr[11:0];
            end
        end
    end

    // ==========================================================
    // wishbone slave
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
            ctrl_q <= `CBCLD_RST_CTRL;
        end else if (ce_i) begin
            ack_q <= bus_req;
            if (bus_req && wb_we_i && wb_sel_i[0]
                    && wb_adr_i == `CBCLD_OFS_CTRL) begin
                ctrl_q <= wb_dat_i[1:0];
            end
            if (bus_req) begin
                case (wb_adr_i)
                    `CBCLD_OFS_CTRL: rdat_q <= {30'h0, ctrl_q};
                    `CBCLD_OFS_STATUS: rdat_q <= {20'h0, bsr_q, 2'h0,
                        peie_q, gie_q, wr_busy_q, standby_q,
                        powerdown_q, timeout_q};
                    `CBCLD_OFS_TBLPTR:
                        rdat_q <= {{(32-TP_W){1'b0}}, tp_q};
                    `CBCLD_OFS_PTR0: rdat_q <= {20'h0, ptr_q[0]};
                    `CBCLD_OFS_PTR1: rdat_q <= {20'h0, ptr_q[1]};
                    `CBCLD_OFS_PTR2: rdat_q <= {20'h0, ptr_q[2]};
                    default: rdat_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ==========================================================
    // outputs
    assign dec_o = dec_q;
    assign dec_valid_o = valid_q;
    assign wdt_restart_o = wdt_q;
    assign soft_reset_o = rst_q;
    assign presc_clr_o = presc_q;
    assign mem_wr_start_o = mst_q;
    assign standby_o = standby_q;
    assign wb_dat_o = rdat_q;
    assign wb_ack_o = ack_q;

endmodule : cbcld_decoder

/* dv/cbcld_decoder_assertions.sv */
/* port checker for the decoder.
   bound below to every cbcld_decoder instance. */
`timescale 1ns/100ps
module cbcld_decoder_chk (
    // watched ports
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic [15:0] instr_i,
    input wire logic instr_valid_i,
    input wire logic wake_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wdt_restart_o,
    input wire logic soft_reset_o,
    input wire logic standby_o,
    input wire logic wb_ack_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    // =============================
    // assertions
    AST_WDT_CAUSE:
        assert property (wdt_restart_o && $past(ce_i) |-> $past(instr_valid_i)
        && ($past(instr_i) == 16'h0004 || $past(instr_i) == 16'h0003))
        else $error("watchdog pulse without cause");
    AST_RST_CAUSE:
        assert property (soft_reset_o && $past(ce_i) |->
        $past(instr_valid_i) && $past(instr_i) == 16'h00ff)
        else $error("reset pulse without cause");
    AST_RST_PULSE:
        assert property (soft_reset_o && ce_i |=> !soft_reset_o)
        else $error("reset pulse too long");
    AST_STBY_CAUSE:
        assert property ($rose(standby_o) |-> $past(instr_i) == 16'h0003)
        else $error("standby without cause");
    AST_WAKE:
        assert property (wake_i && ce_i && !(instr_valid_i
        && instr_i == 16'h0003) |=> !standby_o) else $error("wake ignored");
    AST_ACK_ONE:
        assert property (wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("ack too long");
    AST_ACK_CAUSE:
        assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    AST_ACK_TIME:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=>
        wb_ack_o) else $error("ack late");
endmodule : cbcld_decoder_chk

bind cbcld_decoder cbcld_decoder_chk u_chk (.ref_clk_i, .nrst_i, .ce_i,
    .instr_i, .instr_valid_i, .wake_i, .wb_cyc_i, .wb_stb_i,
    .wdt_restart_o, .soft_reset_o, .standby_o, .wb_ack_o);

/* dv/cbcld_decoder_tb.sv */
/* bench: two register bus checks, table rows, then hand-written cases.
   assumes the port checker is bound to the decoder. */
`timescale 1ns/100ps
module cbcld_decoder_tb;
    logic ref_clk_i, nrst_i, ce_i, instr_valid_i, wake_i, mem_wr_done_i;
    logic dec_valid_o, wdt_restart_o, soft_reset_o, presc_clr_o;
    logic mem_wr_start_o, standby_o, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
    logic [15:0] instr_i;
    logic [7:0] file_rd_i, port_pins_i, wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rv;
    logic [$bits(cbcld_pkg::cbcld_dec_t)-1:0] dec_o;
    cbcld_pkg::cbcld_flags_t flags_i;
    cbcld_pkg::cbcld_dec_t d;
    cbcld_pkg::cbcld_op_t op_n = cbcld_pkg::nop_op;
    cbcld_pkg::cbcld_op_t op_a = cbcld_pkg::add_literal_op;
    int bad_count, tests_run, cyc_cnt, p, i;
    logic [15:0] rw [18] = '{16'h0f15, 16'h0815, 16'h0b33, 16'h0933,
        16'h0a33, 16'h9234, 16'h8234, 16'h7234, 16'h0105, 16'h0004,
        16'h0005, 16'h0006, 16'ha234, 16'hb234, 16'hd005, 16'h0c7e,
        16'h00ff, 16'h0011};
    cbcld_pkg::cbcld_op_t ro [18] = '{op_a,
        cbcld_pkg::subtract_from_literal_op, cbcld_pkg::and_literal_op,
        cbcld_pkg::or_literal_op, cbcld_pkg::xor_literal_op,
        cbcld_pkg::bit_clear_op, cbcld_pkg::bit_set_op,
        cbcld_pkg::bit_toggle_op, cbcld_pkg::bank_select_load_op,
        cbcld_pkg::watchdog_clear_op, cbcld_pkg::push_op, cbcld_pkg::pop_op,
        cbcld_pkg::bit_test_skip_set_op, cbcld_pkg::bit_test_skip_clear_op,
        cbcld_pkg::unconditional_branch_op,
        cbcld_pkg::return_with_literal_op, cbcld_pkg::soft_reset_op,
        cbcld_pkg::interrupt_return_op};
    assign d = dec_o;
    cbcld_decoder uut (.ref_clk_i, .nrst_i, .ce_i, .instr_i, .instr_valid_i,
        .file_rd_i, .flags_i, .port_pins_i, .wake_i, .mem_wr_done_i, .dec_o,
        .dec_valid_o, .wdt_restart_o, .soft_reset_o, .presc_clr_o,
        .mem_wr_start_o, .standby_o, .wb_adr_i, .wb_dat_i, .wb_sel_i,
        .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o);
    // =============================
    // tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic ins(input logic [15:0] w);
        @(posedge ref_clk_i);
        instr_i <= w;
        instr_valid_i <= 1'b1;
        @(posedge ref_clk_i);
        instr_valid_i <= 1'b0;
        #1;
    endtask : ins
    task automatic bus(input logic [7:0] a, input logic w);
        @(posedge ref_clk_i);
        wb_adr_i <= a;
        wb_we_i <= w;
        wb_dat_i <= 32'h3;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do @(posedge ref_clk_i); while (wb_ack_o !== 1'b1);
        rv = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : bus
    task automatic complete_run;
        if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 2000) begin
            bad_count++;
            complete_run();
        end
    end
    // =============================
    // main sequence
    initial begin
        {nrst_i, instr_valid_i, wake_i, mem_wr_done_i, wb_we_i} = '0;
        {wb_cyc_i, wb_stb_i, instr_i, file_rd_i, flags_i, wb_adr_i} = '0;
        {ce_i, wb_dat_i, port_pins_i, wb_sel_i} = {1'b1, 32'h0, 12'h5af};
        repeat (4) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        bus(8'h04, 1'b0);
        chk(rv, 32'h3);
        bus(8'h40, 1'b1);
        bus(8'h40, 1'b0);
        chk(rv, 32'h0);
        for (i = 0; i < 18; i++) begin
            ins(rw[i]);
            chk(d.op, ro[i]);
            chk(dec_valid_o, 1'b1);
            if (i == 16) chk(soft_reset_o, 1'b1);
            if (i < 12) chk(d.flag_mask, i < 2 ? 5'h1f : i < 5 ? 5'h14 : 5'h0);
            ins(16'h0f00);
            chk(d.op, i > 12 && i != 16 ? op_n : op_a);
        end
        bus(8'h04, 1'b0);
        chk(rv, 32'h33);
        for (i = 0; i < 16; i++) begin
            flags_i <= {5{i[3]}};
            ins({5'b11100, i[2:0], 8'hf0});
            chk(d.offset, 11'h7f0);
            ins(16'h0f00);
            chk(d.op, i[0] ^ i[3] ? op_n : op_a);
        end
        ins(16'hec12);
        chk(d.op, op_n);
        ins(16'hf345);
        chk(d.addr, 32'h34512);
        ins(16'h0000);
        ins(16'hef12);
        ins(16'hf345);
        chk(d.op, cbcld_pkg::absolute_jump_op);
        ins(16'h0000);
        ins(16'hf345);
        chk(d.op, op_n);
        ins(16'hee25);
        ins(16'hf0ab);
        chk(d.sel, 2'h2);
        for (i = 0; i < 8; i++) begin
            p += i % 4 == 3;
            ins(16'h0008 + 16'(i));
            chk(d.addr, p);
            chk(d.op, i < 4 ? cbcld_pkg::table_read_op : cbcld_pkg::table_write_op);
            p += (i % 4 == 1) - (i % 4 == 2);
        end
        bus(8'h00, 1'b1);
        ins(16'h000c);
        chk(mem_wr_start_o, 1'b1);
        ins(16'h000c);
        chk(mem_wr_start_o, 1'b0);
        ins(16'h90d6);
        chk(presc_clr_o, 1'b1);
        ins(16'h7080);
        chk(d.pins_src, 1'b1);
        ins(16'h0003);
        chk(wdt_restart_o, 1'b1);
        chk(standby_o, 1'b1);
        bus(8'h04, 1'b0);
        chk(rv[3:0], 4'hd);
        wake_i <= 1'b1;
        mem_wr_done_i <= 1'b1;
        ins(16'h0004);
        bus(8'h04, 1'b0);
        chk(rv[3:0], 4'h3);
        chk(standby_o, 1'b0);
        nrst_i <= 1'b0;
        @(posedge ref_clk_i);
        chk(d.op, op_n);
        nrst_i <= 1'b1;
        bus(8'h04, 1'b0);
        chk(rv, 32'h3);
        complete_run();
    end
endmodule : cbcld_decoder_tb
